// file: verilog/ptpic_cfg.svh
// Offsets, field positions, reset values and timing counts of the PTP instance block
//
// How it works
// - Disabled instance neither sends nor accepts messages
// - Echo answers follow port enable alone
// - Leader-only role is Active or Passive only
// - Follower-only role never leads, still locks
// - Ordinary clock follows instead of going Passive
// - Default domain 127 media, else 0
// - Defaults: priorities 128, timeout 3, intervals
// - Multicast model multicasts every message
// - Unicast model uses candidate leader list, not leader
// - Mixed: multicast general, unicast delay exchange
// - Mixed only follower-only, not audio profile
// - Combined setting leader-only, not audio profile
// - Domain limited to 0 to 127
// - Priorities 0-255, locked in follower-only role except when a defaults load sets them to 128
// - Dynamic priority off, on P1 or P2
// - Restore drops offset, reruns selection
// - Dynamic offset 2 to 10, floor 0
// - Announce discarded when steps reach limit, not leader
// - Asymmetry -20 to +20 us, not leader
// - Announce interval: leader period, unicast grant rate
// - Missing Announces declare leader lost, reselect
`ifndef PTPIC_CFG_SVH
`define PTPIC_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PTPIC_OFF_CTRL 12'h000
`define PTPIC_OFF_DOMAIN 12'h004
`define PTPIC_OFF_PRIO 12'h008
`define PTPIC_OFF_MSG 12'h00C
`define PTPIC_OFF_FOLLOW 12'h010
`define PTPIC_OFF_STATUS 12'h014
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PTPIC_CTRL_EN 0
`define PTPIC_CTRL_ROLE 2:1
`define PTPIC_CTRL_PROF 4:3
`define PTPIC_CTRL_MODEL 6:5
`define PTPIC_CTRL_DYN 8:7
`define PTPIC_CTRL_LOAD 9
`define PTPIC_CTRL_RESTORE 10
`define PTPIC_PRIO_P1 7:0
`define PTPIC_PRIO_P2 15:8
`define PTPIC_PRIO_OFS 19:16
`define PTPIC_MSG_ANN 3:0
`define PTPIC_MSG_SYNC 7:4
`define PTPIC_MSG_TMO 11:8
`define PTPIC_FOL_STEPS 7:0
`define PTPIC_FOL_ASYM 21:16
// ----------------------------------------
// Reset and profile default values
// ----------------------------------------
`define PTPIC_DOM_MEDIA 7'h7F
`define PTPIC_DOM_OTHER 7'h00
`define PTPIC_DOM_MAX 7'h7F
`define PTPIC_PRIO_DEF 8'h80
`define PTPIC_TMO_DEF 4'h3
`define PTPIC_ANN_MEDIA 4'h0
`define PTPIC_ANN_OTHER 4'h1
`define PTPIC_SYNC_DEF 4'hD
`define PTPIC_SYNC_GEN 4'h0
`define PTPIC_OFS_MIN 4'h2
`define PTPIC_OFS_MAX 4'hA
`define PTPIC_STEPS_DEF 8'hFF
`define PTPIC_ASYM_MIN (-6'sd20)
`define PTPIC_ASYM_MAX (6'sd20)
// ----------------------------------------
// Timing
// ----------------------------------------
`define PTPIC_CLK_PERIOD_NS 50
`define PTPIC_SECOND_NS 1000000000
`define PTPIC_SECOND_CYCLES (`PTPIC_SECOND_NS / `PTPIC_CLK_PERIOD_NS)
`endif

// file: verilog/ptpic_pkg.sv
// Types shared by the PTP instance block
`default_nettype none
package ptpic_pkg;
  typedef enum logic [1:0] {PTPIC_LEADER = 2'h0, PTPIC_FOLLOWER = 2'h1, PTPIC_ORDINARY = 2'h2} ptpic_role_t;
  typedef enum logic [1:0] {PTPIC_MEDIA = 2'h0, PTPIC_AUDIO = 2'h1, PTPIC_GENERIC = 2'h2} ptpic_prof_t;
  typedef enum logic [1:0] {PTPIC_MCAST = 2'h0, PTPIC_UCAST = 2'h1, PTPIC_MIXED = 2'h2, PTPIC_BOTH = 2'h3} ptpic_model_t;
  typedef enum logic [1:0] {PTPIC_DYN_OFF = 2'h0, PTPIC_DYN_P1 = 2'h1, PTPIC_DYN_P2 = 2'h2} ptpic_dyn_t;
  typedef enum logic [4:0] {
    PTPIC_ST_OFF = 5'h01, PTPIC_ST_LISTEN = 5'h02, PTPIC_ST_ACTIVE = 5'h04,
    PTPIC_ST_PASSIVE = 5'h08, PTPIC_ST_FOLLOW = 5'h10
  } ptpic_state_t;
  // Received Announce summary from the message parser
  typedef struct packed {
    logic valid;
    logic from_leader;
    logic [7:0] steps;
  } ptpic_ann_t;
  // Addressing choices for the transmit path
  typedef struct packed {
    logic gen_mcast;
    logic delay_ucast;
    logic resp_mirror;
    logic use_list;
  } ptpic_addr_t;
endpackage : ptpic_pkg
`default_nettype wire

// file: verilog/ptpic_top.sv
// PTP instance configuration, role state and leader-loss timing with APB registers
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ptpic_cfg.svh"
module ptpic_top import ptpic_pkg::*; #(
  parameter int unsigned SECOND_CYCLES = `PTPIC_SECOND_CYCLES
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic PORT_EN_I,
  input wire ptpic_ann_t ANN_RX_I,
  input wire logic SEL_DONE_I,
  input wire logic SEL_LOCAL_I,
  output logic TX_PERMIT_O,
  output logic RX_PERMIT_O,
  output logic PING_ANSWER_O,
  output ptpic_addr_t ADDR_O,
  output logic ANN_TX_O,
  output logic LEADER_LOST_O,
  output logic SEL_RERUN_O,
  output logic [7:0] APPLIED_P1_O,
  output logic [7:0] APPLIED_P2_O,
  output logic [3:0] GRANT_ANN_O,
  output logic [3:0] GRANT_SYNC_O,
  output logic signed [5:0] ASYM_O
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Interval code is log2 seconds, two's complement
  function automatic logic [31:0] ptpic_ivl(input logic [3:0] lg);
    logic [31:0] sec;
    sec = SECOND_CYCLES;
    if (!lg[3]) begin
      ptpic_ivl = sec << lg;
    end else begin
      ptpic_ivl = sec >> (4'h0 - lg);
    end
  endfunction : ptpic_ivl

  // Base minus offset, held at zero
  function automatic logic [7:0] ptpic_sub(input logic [7:0] b, input logic [3:0] o);
    ptpic_sub = (b > {4'h0, o}) ? (b - {4'h0, o}) : 8'h00;
  endfunction : ptpic_sub

  function automatic logic model_ok(input logic [1:0] m, input logic [1:0] r, input logic [1:0] p);
    model_ok = (m == PTPIC_MIXED) ? (r == PTPIC_FOLLOWER && p != PTPIC_AUDIO) :
               (m == PTPIC_BOTH) ? (r == PTPIC_LEADER && p != PTPIC_AUDIO) : 1'b1;
  endfunction : model_ok

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic en, next_en;
  logic [1:0] role, next_role, prof, next_prof, model, next_model, dyn, next_dyn;
  logic [6:0] domain, next_domain;
  logic [7:0] p1, next_p1, p2, next_p2, steps_max, next_steps_max;
  logic [3:0] ofs, next_ofs, ann_lg, next_ann_lg, sync_lg, next_sync_lg, tmo, next_tmo;
  logic signed [5:0] asym, next_asym;
  logic wr, rd_setup, restore_cmd;
  logic [31:0] next_prdata, rdata;
  logic [4:0] st;
  ptpic_state_t state, next_state;
  assign st = state;

  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign restore_cmd = wr && PADDR_I == `PTPIC_OFF_CTRL && PWDATA_I[`PTPIC_CTRL_RESTORE];

  // Illegal field values are dropped field by field; a model left illegal by the new role or profile falls back to multicast
  always_comb begin
    next_en = en;
    next_role = role;
    next_prof = prof;
    next_model = model;
    next_dyn = dyn;
    next_domain = domain;
    next_p1 = p1;
    next_p2 = p2;
    next_ofs = ofs;
    next_ann_lg = ann_lg;
    next_sync_lg = sync_lg;
    next_tmo = tmo;
    next_steps_max = steps_max;
    next_asym = asym;
    if (wr) begin
      unique case (PADDR_I)
        `PTPIC_OFF_CTRL: begin
          next_en = PWDATA_I[`PTPIC_CTRL_EN];
          if (PWDATA_I[`PTPIC_CTRL_ROLE] != 2'h3) begin
            next_role = PWDATA_I[`PTPIC_CTRL_ROLE];
          end
          if (PWDATA_I[`PTPIC_CTRL_PROF] != 2'h3) begin
            next_prof = PWDATA_I[`PTPIC_CTRL_PROF];
          end
          if (PWDATA_I[`PTPIC_CTRL_DYN] != 2'h3) begin
            next_dyn = PWDATA_I[`PTPIC_CTRL_DYN];
          end
          // Model checked against the role and profile being written
          if (model_ok(PWDATA_I[`PTPIC_CTRL_MODEL], next_role, next_prof)) begin
            next_model = PWDATA_I[`PTPIC_CTRL_MODEL];
          end else if (!model_ok(model, next_role, next_prof)) begin
            next_model = PTPIC_MCAST;
          end
          if (PWDATA_I[`PTPIC_CTRL_LOAD]) begin
            next_domain = (next_prof == PTPIC_MEDIA) ? `PTPIC_DOM_MEDIA : `PTPIC_DOM_OTHER;
            next_p1 = `PTPIC_PRIO_DEF;
            next_p2 = `PTPIC_PRIO_DEF;
            next_tmo = `PTPIC_TMO_DEF;
            next_ann_lg = (next_prof == PTPIC_MEDIA) ? `PTPIC_ANN_MEDIA : `PTPIC_ANN_OTHER;
            next_sync_lg = (next_prof == PTPIC_GENERIC) ? `PTPIC_SYNC_GEN : `PTPIC_SYNC_DEF;
          end
        end
        `PTPIC_OFF_DOMAIN: begin
          next_domain = PWDATA_I[6:0];
        end
        `PTPIC_OFF_PRIO: begin
          if (role != PTPIC_FOLLOWER) begin
            next_p1 = PWDATA_I[`PTPIC_PRIO_P1];
            next_p2 = PWDATA_I[`PTPIC_PRIO_P2];
            if (PWDATA_I[`PTPIC_PRIO_OFS] >= `PTPIC_OFS_MIN && PWDATA_I[`PTPIC_PRIO_OFS] <= `PTPIC_OFS_MAX) begin
              next_ofs = PWDATA_I[`PTPIC_PRIO_OFS];
            end
          end
        end
        `PTPIC_OFF_MSG: begin
          // Multicast and mixed followers take the leader's rates
          if (role != PTPIC_FOLLOWER || model == PTPIC_UCAST) begin
            next_ann_lg = PWDATA_I[`PTPIC_MSG_ANN];
            next_sync_lg = PWDATA_I[`PTPIC_MSG_SYNC];
          end
          if (PWDATA_I[`PTPIC_MSG_TMO] != 4'h0) begin
            next_tmo = PWDATA_I[`PTPIC_MSG_TMO];
          end
        end
        `PTPIC_OFF_FOLLOW: begin
          if (role != PTPIC_LEADER) begin
            next_steps_max = PWDATA_I[`PTPIC_FOL_STEPS];
            if ($signed(PWDATA_I[`PTPIC_FOL_ASYM]) >= `PTPIC_ASYM_MIN
                && $signed(PWDATA_I[`PTPIC_FOL_ASYM]) <= `PTPIC_ASYM_MAX) begin
              next_asym = $signed(PWDATA_I[`PTPIC_FOL_ASYM]);
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Register read data, captured in the setup cycle
  always_comb begin
    unique case (PADDR_I)
      `PTPIC_OFF_CTRL: rdata = {21'h0, 2'h0, dyn, model, prof, role, en};
      `PTPIC_OFF_DOMAIN: rdata = {25'h0, domain};
      `PTPIC_OFF_PRIO: rdata = {12'h0, ofs, p2, p1};
      `PTPIC_OFF_MSG: rdata = {20'h0, tmo, sync_lg, ann_lg};
      `PTPIC_OFF_FOLLOW: rdata = {10'h0, asym, 8'h0, steps_max};
      `PTPIC_OFF_STATUS: rdata = {11'h0, st, APPLIED_P2_O, APPLIED_P1_O};
      default: rdata = 32'h0;
    endcase
    next_prdata = rd_setup ? rdata : PRDATA_O;
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      en <= 1'b0;
      role <= PTPIC_LEADER;
      prof <= PTPIC_MEDIA;
      model <= PTPIC_MCAST;
      dyn <= PTPIC_DYN_OFF;
      domain <= `PTPIC_DOM_MEDIA;
      p1 <= `PTPIC_PRIO_DEF;
      p2 <= `PTPIC_PRIO_DEF;
      ofs <= `PTPIC_OFS_MIN;
      ann_lg <= `PTPIC_ANN_MEDIA;
      sync_lg <= `PTPIC_SYNC_DEF;
      tmo <= `PTPIC_TMO_DEF;
      steps_max <= `PTPIC_STEPS_DEF;
      asym <= 6'sd0;
      PRDATA_O <= 32'h0;
    end else begin
      en <= next_en;
      role <= next_role;
      prof <= next_prof;
      model <= next_model;
      dyn <= next_dyn;
      domain <= next_domain;
      p1 <= next_p1;
      p2 <= next_p2;
      ofs <= next_ofs;
      ann_lg <= next_ann_lg;
      sync_lg <= next_sync_lg;
      tmo <= next_tmo;
      steps_max <= next_steps_max;
      asym <= next_asym;
      PRDATA_O <= next_prdata;
    end
  end

  // Zero wait states; unmapped offsets flag an error
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && (PADDR_I > `PTPIC_OFF_STATUS || PADDR_I[1:0] != 2'h0);

  // ----------------------------------------
  // Role state and leader-loss timing
  // ----------------------------------------
  logic ann_ok, ivl_tick, lost, restored, next_restored, rerun, next_rerun;
  logic [31:0] cnt, next_cnt;
  logic [3:0] miss, next_miss;

  // Only Announces below the step limit refresh the leader; leader-only ignores the limit
  assign ann_ok = en && ANN_RX_I.valid && ANN_RX_I.from_leader
                  && (role == PTPIC_LEADER || ANN_RX_I.steps < steps_max);
  assign ivl_tick = cnt >= ptpic_ivl(ann_lg) - 32'h1;
  // An Announce that lands on the last tick still saves the leader
  assign lost = ivl_tick && miss + 4'h1 >= tmo && !ann_ok
                && (state == PTPIC_ST_PASSIVE || state == PTPIC_ST_FOLLOW);

  always_comb begin
    next_state = state;
    next_restored = restored;
    next_rerun = 1'b0;
    next_cnt = ivl_tick ? 32'h0 : cnt + 32'h1;
    next_miss = ivl_tick ? miss + 4'h1 : miss;
    if (ann_ok) begin
      next_cnt = 32'h0;
      next_miss = 4'h0;
    end
    unique case (state)
      PTPIC_ST_OFF: begin
        if (en) begin
          next_state = PTPIC_ST_LISTEN;
        end
      end
      PTPIC_ST_LISTEN, PTPIC_ST_ACTIVE: begin
        if (SEL_DONE_I) begin
          if (SEL_LOCAL_I && role != PTPIC_FOLLOWER) begin
            next_state = PTPIC_ST_ACTIVE;
          end else if (role == PTPIC_LEADER) begin
            next_state = PTPIC_ST_PASSIVE;
          end else begin
            next_state = PTPIC_ST_FOLLOW;
          end
        end else if (state == PTPIC_ST_ACTIVE && role == PTPIC_FOLLOWER) begin
          // Role rewritten to follower-only: stop leading at once
          next_state = PTPIC_ST_LISTEN;
        end
      end
      PTPIC_ST_PASSIVE, PTPIC_ST_FOLLOW: begin
        if (lost) begin
          // Passive leader starts announcing; follower reselects
          next_state = (state == PTPIC_ST_PASSIVE) ? PTPIC_ST_ACTIVE : PTPIC_ST_LISTEN;
          next_rerun = 1'b1;
        end else if (SEL_DONE_I && SEL_LOCAL_I && role == PTPIC_ORDINARY) begin
          next_state = PTPIC_ST_ACTIVE;
        end else if (role != PTPIC_LEADER && state == PTPIC_ST_PASSIVE) begin
          next_state = PTPIC_ST_FOLLOW;
        end else if (role == PTPIC_LEADER && state == PTPIC_ST_FOLLOW) begin
          next_state = PTPIC_ST_PASSIVE;
        end
      end
      default: begin
        next_state = PTPIC_ST_OFF;
      end
    endcase
    // Misses only count while another clock leads
    if (lost || !(state == PTPIC_ST_PASSIVE || state == PTPIC_ST_FOLLOW)) begin
      next_miss = 4'h0;
    end
    if (!en) begin
      next_state = PTPIC_ST_OFF;
    end
    // Restore holds until the instance leaves the Active state
    if (state == PTPIC_ST_ACTIVE && restore_cmd && dyn != PTPIC_DYN_OFF && !restored) begin
      next_restored = 1'b1;
      next_rerun = 1'b1;
    end else if (next_state != PTPIC_ST_ACTIVE) begin
      next_restored = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state <= PTPIC_ST_OFF;
      cnt <= 32'h0;
      miss <= 4'h0;
      restored <= 1'b0;
      rerun <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      miss <= next_miss;
      restored <= next_restored;
      rerun <= next_rerun;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic dyn_on;
  assign dyn_on = state == PTPIC_ST_ACTIVE && !restored;
  assign APPLIED_P1_O = (dyn_on && dyn == PTPIC_DYN_P1) ? ptpic_sub(p1, ofs) : p1;
  assign APPLIED_P2_O = (dyn_on && dyn == PTPIC_DYN_P2) ? ptpic_sub(p2, ofs) : p2;
  assign TX_PERMIT_O = en;
  assign RX_PERMIT_O = en;
  assign PING_ANSWER_O = PORT_EN_I;
  assign ANN_TX_O = state == PTPIC_ST_ACTIVE && ivl_tick;
  assign LEADER_LOST_O = rerun && state != PTPIC_ST_ACTIVE || rerun && restored == 1'b0 && state == PTPIC_ST_ACTIVE;
  assign SEL_RERUN_O = rerun;
  assign ADDR_O.gen_mcast = model != PTPIC_UCAST;
  assign ADDR_O.delay_ucast = model == PTPIC_UCAST || model == PTPIC_MIXED;
  assign ADDR_O.resp_mirror = model == PTPIC_BOTH;
  assign ADDR_O.use_list = model == PTPIC_UCAST && role != PTPIC_LEADER;
  assign GRANT_ANN_O = ann_lg;
  assign GRANT_SYNC_O = sync_lg;
  assign ASYM_O = asym;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_off_silent: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    !en |-> !TX_PERMIT_O && !RX_PERMIT_O ##1 state == PTPIC_ST_OFF) else $error("disabled instance active");
  a_ping_kept: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (PORT_EN_I && !en) |-> PING_ANSWER_O) else $error("ping dropped");
  a_leader_role: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    role == PTPIC_LEADER && $stable(role) |-> state != PTPIC_ST_FOLLOW) else $error("leader-only followed");
  a_follower_role: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    role == PTPIC_FOLLOWER && $past(role) == PTPIC_FOLLOWER |-> state != PTPIC_ST_ACTIVE)
    else $error("follower-only led");
  a_model_legal: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    model == PTPIC_MIXED |-> role == PTPIC_FOLLOWER && prof != PTPIC_AUDIO) else $error("illegal mixed");
  a_both_legal: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    model == PTPIC_BOTH |-> role == PTPIC_LEADER && prof != PTPIC_AUDIO) else $error("illegal combined");
  a_media_dom: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr && PADDR_I == `PTPIC_OFF_CTRL && PWDATA_I[9] && PWDATA_I[4:3] == 2'h0 |=> domain == 7'h7F && tmo == 4'h3)
    else $error("bad defaults");
  a_prio_lock: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    role == PTPIC_FOLLOWER && !(wr && PADDR_I == `PTPIC_OFF_CTRL) |=> $stable(p1) && $stable(p2))
    else $error("priority changed");
  a_ofs_range: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    ofs >= 4'h2 && ofs <= 4'hA) else $error("offset out of range");
  a_loss_rerun: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    lost && en |=> SEL_RERUN_O && (state == PTPIC_ST_ACTIVE || state == PTPIC_ST_LISTEN))
    else $error("loss not acted on");
endmodule : ptpic_top
`default_nettype wire

// file: dv/ptpic_far_clock.sv
// Far-side clock model: current leader's Announce source and best-leader selection
`timescale 1ns/1ps
`default_nettype none
module ptpic_far_clock import ptpic_pkg::*; #(
  parameter int GAP = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic beacon_on_i,
  input wire logic [7:0] beacon_steps_i,
  input wire logic pick_req_i,
  input wire logic pick_local_i,
  input wire logic pick_slow_i,
  output ptpic_ann_t ann_o,
  output logic sel_done_o,
  output logic sel_local_o
);
  int gap_cnt;
  int pick_cnt;
  // ----------------------------------------
  // Announce source
  // ----------------------------------------
  // Between beats valid stays low while from_leader and steps toggle, so the block cannot lean on stale values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_cnt <= 0;
      ann_o <= '0;
    end else if (beacon_on_i && gap_cnt == GAP - 1) begin
      gap_cnt <= 0;
      ann_o <= {1'b1, 1'b1, beacon_steps_i};
    end else begin
      gap_cnt <= beacon_on_i ? gap_cnt + 1 : 0;
      ann_o <= {1'b0, ~ann_o.from_leader, ~ann_o.steps};
    end
  end
  // ----------------------------------------
  // Selection result, prompt or slow
  // ----------------------------------------
  // The winner flag is only meaningful with the done pulse; it toggles otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pick_cnt <= 0;
      sel_done_o <= 1'b0;
      sel_local_o <= 1'b0;
    end else if (pick_req_i) begin
      pick_cnt <= pick_slow_i ? 6 : 1;
      sel_done_o <= 1'b0;
      sel_local_o <= ~sel_local_o;
    end else if (pick_cnt == 1) begin
      pick_cnt <= 0;
      sel_done_o <= 1'b1;
      sel_local_o <= pick_local_i;
    end else begin
      pick_cnt <= (pick_cnt > 0) ? pick_cnt - 1 : 0;
      sel_done_o <= 1'b0;
      sel_local_o <= ~sel_local_o;
    end
  end
endmodule : ptpic_far_clock
`default_nettype wire

// file: dv/ptpic_top_tb.sv
// Self-checking testbench of the PTP instance block
`timescale 1ns/1ps
`default_nettype none
`include "ptpic_cfg.svh"
module ptpic_top_tb import ptpic_pkg::*;;
  logic clk, rst, psel, penable, pwrite, port_en, pick_req, pick_local, pick_slow, beacon_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic pready, pslverr, sel_done, sel_local, tx_permit, rx_permit, ping, ann_tx, lost, rerun;
  logic [7:0] steps, ap1, ap2;
  logic [3:0] gann, gsync;
  logic signed [5:0] asym;
  ptpic_ann_t ann;
  ptpic_addr_t addr;
  logic [65:0] exp_q[$];
  logic [65:0] e;
  int failures, checks_done, n_ann, n_lost, n_rerun, c;
  ptpic_top #(.SECOND_CYCLES(16)) uut (.CORE_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PORT_EN_I(port_en), .ANN_RX_I(ann), .SEL_DONE_I(sel_done), .SEL_LOCAL_I(sel_local),
    .TX_PERMIT_O(tx_permit), .RX_PERMIT_O(rx_permit), .PING_ANSWER_O(ping), .ADDR_O(addr), .ANN_TX_O(ann_tx),
    .LEADER_LOST_O(lost), .SEL_RERUN_O(rerun), .APPLIED_P1_O(ap1), .APPLIED_P2_O(ap2), .GRANT_ANN_O(gann),
    .GRANT_SYNC_O(gsync), .ASYM_O(asym));
  ptpic_far_clock #(.GAP(16)) far (.clk_i(clk), .rst_i(rst), .beacon_on_i(beacon_on), .beacon_steps_i(steps),
    .pick_req_i(pick_req), .pick_local_i(pick_local), .pick_slow_i(pick_slow), .ann_o(ann),
    .sel_done_o(sel_done), .sel_local_o(sel_local));
  // ----------------------------------------
  // Clock, pulse counters and read monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pulses last one cycle, so they are tallied at every edge
  always @(posedge clk) begin
    n_ann += int'(ann_tx === 1'b1);
    n_lost += int'(lost === 1'b1);
    n_rerun += int'(rerun === 1'b1);
  end
  // Each completed read takes the oldest note; the mask hides data on error answers
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) begin
        e = {66{1'b1}};
      end else begin
        e = exp_q.pop_front();
      end
      chk({pslverr, prdata} & e[65:33], e[32:0]);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask : chk
  // APB transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
    #1;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFFFF_FFFF);
    exp_q.push_back({1'b1, m, 1'b0, x});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : settle
  task automatic pick(input logic l, input logic s);
    @(posedge clk);
    pick_req <= 1'b1;
    pick_local <= l;
    pick_slow <= s;
    @(posedge clk);
    pick_req <= 1'b0;
    settle(10);
  endtask : pick
  task automatic beacon(input logic on, input logic [7:0] st);
    @(posedge clk);
    beacon_on <= on;
    steps <= st;
  endtask : beacon
  // Bounded wait for a leader-loss pulse beyond the given count
  task automatic wait_lost(input int base, input int lim);
    for (int i = 0; i < lim && n_lost == base; i++) @(posedge clk);
    #1;
    if (n_lost == base) begin
      failures++;
      end_of_test();
    end
  endtask : wait_lost
  task automatic end_of_test();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, psel, penable, pwrite, port_en, pick_req, pick_local, pick_slow, beacon_on} = 9'h100;
    {paddr, pwdata, steps} = '0;
    d = $urandom(32'h75C9);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    port_en <= 1'b1;
    rd(`PTPIC_OFF_CTRL, 32'h0);
    rd(`PTPIC_OFF_DOMAIN, 32'h7F);
    rd(`PTPIC_OFF_PRIO, 32'h0002_8080);
    rd(`PTPIC_OFF_MSG, 32'h3D0);
    rd(`PTPIC_OFF_STATUS, {11'h0, PTPIC_ST_OFF, 16'h8080});
    exp_q.push_back({33'h1_0000_0000, 33'h1_0000_0000});
    apb(1'b0, 12'h018, 32'h0);
    chk(33'({tx_permit, rx_permit, ping}), 33'h1);
    wr(`PTPIC_OFF_DOMAIN, 32'hFF);
    rd(`PTPIC_OFF_DOMAIN, 32'h7F);
    d = 32'($urandom_range(127));
    wr(`PTPIC_OFF_DOMAIN, d);
    rd(`PTPIC_OFF_DOMAIN, d);
    wr(`PTPIC_OFF_PRIO, 32'h0005_140A);
    for (int p = 2; p >= 0; p--) begin
      wr(`PTPIC_OFF_CTRL, 32'(p << 3) | 32'h200);
      rd(`PTPIC_OFF_DOMAIN, (p == 0) ? 32'h7F : 32'h0);
      rd(`PTPIC_OFF_MSG, (p == 2) ? 32'h301 : (32'h3D0 | 32'(p == 1)));
      rd(`PTPIC_OFF_PRIO, 32'h8080, 32'hFFFF);
    end
    wr(`PTPIC_OFF_PRIO, 32'h0005_140A);
    wr(`PTPIC_OFF_PRIO, 32'h000B_140A);
    wr(`PTPIC_OFF_PRIO, 32'h0001_140A);
    rd(`PTPIC_OFF_PRIO, 32'h0005_140A);
    wr(`PTPIC_OFF_CTRL, 32'h101);
    rd(`PTPIC_OFF_STATUS, {11'h0, PTPIC_ST_LISTEN, 16'h140A});
    pick(1'b1, 1'b1);
    rd(`PTPIC_OFF_STATUS, {11'h0, PTPIC_ST_ACTIVE, 16'h0F0A});
    chk(33'({tx_permit, ap2}), 33'h10F);
    c = n_ann;
    settle(64);
    chk(33'(n_ann - c), 33'h4);
    c = n_rerun;
    wr(`PTPIC_OFF_CTRL, 32'h501);
    settle(3);
    chk(33'(ap2), 33'h14);
    wr(`PTPIC_OFF_CTRL, 32'h501);
    settle(3);
    chk(33'(n_rerun - c), 33'h1);
    pick(1'b0, 1'b0);
    rd(`PTPIC_OFF_STATUS, {11'h0, PTPIC_ST_PASSIVE, 16'h140A});
    beacon(1'b1, 8'h00);
    c = n_lost;
    settle(100);
    chk(33'(n_lost - c), 33'h0);
    beacon(1'b0, 8'h00);
    settle(14);
    chk(33'(n_lost - c), 33'h0);
    e[31:0] = 32'(n_rerun);
    wait_lost(c, 60);
    settle(2);
    chk(33'(32'(n_rerun) - e[31:0]), 33'h1);
    rd(`PTPIC_OFF_STATUS, {11'h0, PTPIC_ST_ACTIVE, 16'h0}, 32'h1F_0000);
    wr(`PTPIC_OFF_CTRL, 32'h002);
    chk(33'({tx_permit, rx_permit}), 33'h0);
    wr(`PTPIC_OFF_CTRL, 32'h003);
    wr(`PTPIC_OFF_PRIO, 32'h0003_0101);
    rd(`PTPIC_OFF_PRIO, 32'h0005_140A);
    wr(`PTPIC_OFF_MSG, 32'h0000_0312);
    chk(33'({gann, gsync}), 33'h0D);
    wr(`PTPIC_OFF_FOLLOW, 32'h002C_0002);
    chk(33'(unsigned'(asym)), 33'h2C);
    wr(`PTPIC_OFF_FOLLOW, 32'h0015_0002);
    rd(`PTPIC_OFF_FOLLOW, 32'h002C_0002);
    beacon(1'b1, 8'h01);
    c = n_ann;
    pick(1'b1, 1'b0);
    settle(40);
    chk(33'(n_ann - c), 33'h0);
    pick(1'b0, 1'b0);
    rd(`PTPIC_OFF_STATUS, {11'h0, PTPIC_ST_FOLLOW, 16'h0}, 32'h1F_0000);
    beacon(1'b1, 8'h02);
    c = n_lost;
    wait_lost(c, 90);
    rd(`PTPIC_OFF_STATUS, {11'h0, PTPIC_ST_LISTEN, 16'h0}, 32'h1F_0000);
    beacon(1'b1, 8'h01);
    pick(1'b0, 1'b0);
    c = n_lost;
    settle(100);
    chk(33'(n_lost - c), 33'h0);
    beacon(1'b0, 8'h00);
    wr(`PTPIC_OFF_CTRL, 32'h004);
    wr(`PTPIC_OFF_CTRL, 32'h005);
    pick(1'b0, 1'b1);
    rd(`PTPIC_OFF_STATUS, {11'h0, PTPIC_ST_FOLLOW, 16'h0}, 32'h1F_0000);
    wr(`PTPIC_OFF_CTRL, 32'h04B);
    rd(`PTPIC_OFF_CTRL, 32'h0B, 32'h7F);
    wr(`PTPIC_OFF_CTRL, 32'h043);
    chk(33'({addr.gen_mcast, addr.delay_ucast}), 33'h3);
    wr(`PTPIC_OFF_CTRL, 32'h023);
    chk(33'({addr.gen_mcast, addr.use_list}), 33'h1);
    wr(`PTPIC_OFF_MSG, 32'h0000_0312);
    chk(33'({gann, gsync}), 33'h21);
    wr(`PTPIC_OFF_CTRL, 32'h003);
    chk(33'({addr.gen_mcast, addr.delay_ucast}), 33'h2);
    wr(`PTPIC_OFF_CTRL, 32'h041);
    rd(`PTPIC_OFF_CTRL, 32'h01, 32'h7F);
    wr(`PTPIC_OFF_CTRL, 32'h061);
    chk(33'({addr.gen_mcast, addr.resp_mirror}), 33'h3);
    wr(`PTPIC_OFF_CTRL, 32'h069);
    rd(`PTPIC_OFF_CTRL, 32'h09, 32'h7F);
    settle(4);
    end_of_test();
  end
endmodule : ptpic_top_tb
`default_nettype wire
